// ---- fbp_pkg.sv ----
// fbp_pkg: register map, field layout and types of the full-bridge pwm output stage
package fbp_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_UNIT_CTRL  = 8'h00;
    localparam logic [7:0] REG_SHUT_CTRL  = 8'h04;
    localparam logic [7:0] REG_DB_RESTART = 8'h08;
    localparam logic [7:0] REG_STATE      = 8'h0C;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int UC_MODE_LSB    = 6;
    localparam int UC_POL_LSB     = 0;
    localparam int SC_STATUS_BIT  = 7;
    localparam int SC_SRC_LSB     = 4;
    localparam int SC_AC_LSB      = 2;
    localparam int SC_BD_LSB      = 0;
    localparam int DB_RESTART_BIT = 7;
    localparam int DB_DELAY_LSB   = 0;
    localparam int SRC_C1_BIT     = 0;
    localparam int SRC_C2_BIT     = 1;
    localparam int SRC_INT_BIT    = 2;
    localparam int POL_BD_BIT     = 0;
    localparam int POL_AC_BIT     = 1;
    localparam int MODE_FB_BIT    = 0;
    localparam int MODE_DIR_BIT   = 1;

    // ------------------------------------------------------------------
    // values and timing
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_RESET   = 2'h0;
    localparam logic [1:0] POL_RESET    = 2'h0;
    localparam logic [1:0] PSS_DRIVE_LO = 2'h0;
    localparam logic [1:0] PSS_DRIVE_HI = 2'h1;
    localparam logic [6:0] DELAY_RESET  = 7'h00;
    localparam logic [8:0] DIR_WINDOW_COUNTS = 9'h004;
    localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic a;
        logic b;
        logic c;
        logic d;
    } fbp_quad_type;

    typedef enum logic [1:0] {
        DIR_STEADY = 2'b01,
        DIR_BLANK  = 2'b10
    } fbp_dir_state_type;

endpackage : fbp_pkg

// ---- fbp_bridge.sv ----
// fbp_bridge: full-bridge steering, direction change and auto-shutdown with wishbone registers
//
// Summary of operation
// - forward: a held active, d carries pwm, b and c inactive
// - reverse: c held active, b carries pwm, a and d inactive
// - direction bit change applies in the following pwm cycle
// - four counts before period end: b,d inactive, a,c swap direction
// - modulation of new output resumes at next period start
// - no dead-band delay in full-bridge, not even on direction change
// - three-bit select enables int-pin low and comparator high as shutdown
// - status bit reads 0 when running, 1 while outputs are shut down
// - shutdown sets status, held until firmware or auto-restart clears it
// - shutdown forces pins to safe states without waiting for a clock
// - pairs a/c and b/d each choose drive high, drive low or tri-state
// - shutdown is level based and lasts while source level persists
// - firmware writes to status are ignored while a source is active
// - after restart the waveform resumes only at the next period start
// - writing 1 to status with no source active gives software shutdown
// - auto-restart follows only hardware sources and clears software shutdown
// - restart enable bit lives beside the dead-band delay setting
// - auto-restart clears status in hardware once the source is gone
// - polarity bits set active level separately for a/c and b/d
//
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps

module fbp_bridge (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // pwm time base
    input  wire logic                 pwm_i,
    input  wire logic                 period_end_i,
    input  wire logic [7:0]           period_timer_count_i,
    input  wire logic [7:0]           period_limit_register_i,
    // shutdown sources, asynchronous
    input  wire logic                 ext_int_pin_i,
    input  wire logic [1:0]           comparator_output_i,
    // pin side
    input  wire fbp_pkg::fbp_quad_type pin_direction_latch_i,
    output fbp_pkg::fbp_quad_type     bridge_out_o,
    output fbp_pkg::fbp_quad_type     bridge_oe_n_o,
    // neighbour configuration
    output logic      [6:0]           deadband_delay_o
);

    // ------------------------------------------------------------------
    // registers and wires
    // ------------------------------------------------------------------
    logic [1:0]                  mode_reg;
    logic [1:0]                  output_polarity_select_reg;
    logic                        shutdown_event_status_reg;
    logic [2:0]                  shutdown_source_select_reg;
    logic [1:0]                  pair_ac_shutdown_state_reg;
    logic [1:0]                  pair_bd_shutdown_state_reg;
    logic                        auto_restart_enable_reg;
    logic [6:0]                  deadband_delay_reg;
    logic                        dir_applied_reg;
    logic                        run_reg;
    fbp_pkg::fbp_dir_state_type  dir_state_reg;
    fbp_pkg::fbp_quad_type       act_reg;
    fbp_pkg::fbp_quad_type       act_next;
    logic                        ack_reg;
    logic [31:0]                 dat_reg;
    logic [2:0]                  sync1_reg;
    logic [2:0]                  sync2_reg;
    logic [2:0]                  sync3_reg;
    logic [2:0]                  filt_reg;
    wire logic [2:0]             src_pins = {comparator_output_i, ext_int_pin_i};
    logic                        src_raw;
    logic                        src_filt;
    logic                        force_shut;
    logic                        full_bridge;
    logic                        dir_pending;
    logic                        in_window;
    logic                        modulate;
    logic [8:0]                  counts_left;
    logic                        bus_req;
    logic                        wr_fire;
    logic                        wr_unit;
    logic                        wr_shut;
    logic                        wr_db;

    // ------------------------------------------------------------------
    // shutdown source decoding
    // ------------------------------------------------------------------
    function automatic logic src_active(
        input logic [2:0] sel,
        input logic       int_lvl,
        input logic [1:0] comp
    );
        src_active = (sel[fbp_pkg::SRC_C1_BIT] & comp[0])
                   | (sel[fbp_pkg::SRC_C2_BIT] & comp[1])
                   | (sel[fbp_pkg::SRC_INT_BIT] & ~int_lvl);
    endfunction : src_active

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    sync1_reg[gi] <= (gi == 0);
                    sync2_reg[gi] <= (gi == 0);
                    sync3_reg[gi] <= (gi == 0);
                    filt_reg[gi]  <= (gi == 0);
                end else begin
                    sync1_reg[gi] <= src_pins[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    sync3_reg[gi] <= sync2_reg[gi];
                    if (sync2_reg[gi] == sync3_reg[gi]) begin
                        filt_reg[gi] <= sync3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    // syncs reset to idle levels (int high, comparators low): no false event
    assign src_raw  = src_active(shutdown_source_select_reg, ext_int_pin_i,
                                 comparator_output_i);
    assign src_filt = src_active(shutdown_source_select_reg, filt_reg[0],
                                 filt_reg[2:1]);
    // raw level forces pins at once; the status bit keeps them forced after
    assign force_shut  = src_raw | shutdown_event_status_reg;
    assign full_bridge = mode_reg[fbp_pkg::MODE_FB_BIT];

    // ------------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------------
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign wr_fire = bus_req & wb_we_i & ack_reg & wb_sel_i[0];
    assign wr_unit = wr_fire & (wb_adr_i == fbp_pkg::REG_UNIT_CTRL);
    assign wr_shut = wr_fire & (wb_adr_i == fbp_pkg::REG_SHUT_CTRL);
    assign wr_db   = wr_fire & (wb_adr_i == fbp_pkg::REG_DB_RESTART);
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= fbp_pkg::WORD_ZERO;
        end else if (bus_req & ~ack_reg) begin
            dat_reg <= fbp_pkg::WORD_ZERO;
            case (wb_adr_i)
                fbp_pkg::REG_UNIT_CTRL: begin
                    dat_reg[fbp_pkg::UC_MODE_LSB +: 2] <= mode_reg;
                    dat_reg[fbp_pkg::UC_POL_LSB +: 2]  <= output_polarity_select_reg;
                end
                fbp_pkg::REG_SHUT_CTRL: begin
                    dat_reg[fbp_pkg::SC_STATUS_BIT]  <= shutdown_event_status_reg;
                    dat_reg[fbp_pkg::SC_SRC_LSB +: 3] <= shutdown_source_select_reg;
                    dat_reg[fbp_pkg::SC_AC_LSB +: 2]  <= pair_ac_shutdown_state_reg;
                    dat_reg[fbp_pkg::SC_BD_LSB +: 2]  <= pair_bd_shutdown_state_reg;
                end
                fbp_pkg::REG_DB_RESTART: begin
                    dat_reg[fbp_pkg::DB_RESTART_BIT]   <= auto_restart_enable_reg;
                    dat_reg[fbp_pkg::DB_DELAY_LSB +: 7] <= deadband_delay_reg;
                end
                fbp_pkg::REG_STATE: begin
                    dat_reg[0] <= dir_applied_reg;
                    dat_reg[1] <= dir_state_reg == fbp_pkg::DIR_BLANK;
                    dat_reg[2] <= run_reg;
                    dat_reg[3] <= src_filt;
                end
                default: begin
                    dat_reg <= fbp_pkg::WORD_ZERO;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg                   <= fbp_pkg::MODE_RESET;
            output_polarity_select_reg <= fbp_pkg::POL_RESET;
        end else if (wr_unit) begin
            mode_reg                   <= wb_dat_i[fbp_pkg::UC_MODE_LSB +: 2];
            output_polarity_select_reg <= wb_dat_i[fbp_pkg::UC_POL_LSB +: 2];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shutdown_source_select_reg <= 3'h0;
            pair_ac_shutdown_state_reg <= fbp_pkg::PSS_DRIVE_LO;
            pair_bd_shutdown_state_reg <= fbp_pkg::PSS_DRIVE_LO;
        end else if (wr_shut) begin
            shutdown_source_select_reg <= wb_dat_i[fbp_pkg::SC_SRC_LSB +: 3];
            pair_ac_shutdown_state_reg <= wb_dat_i[fbp_pkg::SC_AC_LSB +: 2];
            pair_bd_shutdown_state_reg <= wb_dat_i[fbp_pkg::SC_BD_LSB +: 2];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            auto_restart_enable_reg <= 1'b0;
            deadband_delay_reg      <= fbp_pkg::DELAY_RESET;
        end else if (wr_db) begin
            auto_restart_enable_reg <= wb_dat_i[fbp_pkg::DB_RESTART_BIT];
            deadband_delay_reg      <= wb_dat_i[fbp_pkg::DB_DELAY_LSB +: 7];
        end
    end
    assign deadband_delay_o = deadband_delay_reg;

    // ------------------------------------------------------------------
    // shutdown status
    // ------------------------------------------------------------------
    // a live source wins over any write, so a clear cannot lose an event
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shutdown_event_status_reg <= 1'b0;
        end else if (src_filt) begin
            shutdown_event_status_reg <= 1'b1;
        end else if (wr_shut) begin
            shutdown_event_status_reg <= wb_dat_i[fbp_pkg::SC_STATUS_BIT];
        end else if (auto_restart_enable_reg) begin
            shutdown_event_status_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // direction change sequence
    // ------------------------------------------------------------------
    assign counts_left = {1'b0, period_limit_register_i} - {1'b0, period_timer_count_i};
    assign in_window   = (period_timer_count_i <= period_limit_register_i)
                       & (counts_left < fbp_pkg::DIR_WINDOW_COUNTS);
    assign dir_pending = dir_applied_reg != mode_reg[fbp_pkg::MODE_DIR_BIT];

    // the swap is not taken on the period-end cycle itself, else the blank
    // would span the whole next period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_state_reg   <= fbp_pkg::DIR_STEADY;
            dir_applied_reg <= 1'b0;
        end else begin
            case (dir_state_reg)
                fbp_pkg::DIR_STEADY: begin
                    if (!full_bridge) begin
                        dir_applied_reg <= mode_reg[fbp_pkg::MODE_DIR_BIT];
                    end else if (dir_pending && in_window && !period_end_i) begin
                        dir_applied_reg <= mode_reg[fbp_pkg::MODE_DIR_BIT];
                        dir_state_reg   <= fbp_pkg::DIR_BLANK;
                    end
                end
                fbp_pkg::DIR_BLANK: begin
                    if (period_end_i || !full_bridge) begin
                        dir_state_reg <= fbp_pkg::DIR_STEADY;
                    end
                end
                default: begin
                    dir_state_reg <= fbp_pkg::DIR_STEADY;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // run gate: waveform restarts only on a period boundary
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_reg <= 1'b0;
        end else if (force_shut || !full_bridge) begin
            run_reg <= 1'b0;
        end else if (period_end_i) begin
            run_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // steering
    // ------------------------------------------------------------------
    // pwm is gated and registered once in act_reg; no dead-band delay stage exists in this path
    assign modulate = pwm_i & run_reg & (dir_state_reg == fbp_pkg::DIR_STEADY);

    always_comb begin
        act_next = '0;
        if (full_bridge) begin
            if (!dir_applied_reg) begin
                act_next.a = 1'b1;
                act_next.d = modulate;
            end else begin
                act_next.c = 1'b1;
                act_next.b = modulate;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            act_reg <= '0;
        end else begin
            act_reg <= act_next;
        end
    end

    // ------------------------------------------------------------------
    // pin drive with asynchronous shutdown override
    // ------------------------------------------------------------------
    // output enable follows the firmware direction latch, low means driving
    always_comb begin
        bridge_out_o.a = act_reg.a ^ output_polarity_select_reg[fbp_pkg::POL_AC_BIT];
        bridge_out_o.c = act_reg.c ^ output_polarity_select_reg[fbp_pkg::POL_AC_BIT];
        bridge_out_o.b = act_reg.b ^ output_polarity_select_reg[fbp_pkg::POL_BD_BIT];
        bridge_out_o.d = act_reg.d ^ output_polarity_select_reg[fbp_pkg::POL_BD_BIT];
        bridge_oe_n_o  = pin_direction_latch_i;
        if (force_shut && full_bridge) begin
            bridge_out_o.a = pair_ac_shutdown_state_reg == fbp_pkg::PSS_DRIVE_HI;
            bridge_out_o.c = pair_ac_shutdown_state_reg == fbp_pkg::PSS_DRIVE_HI;
            bridge_out_o.b = pair_bd_shutdown_state_reg == fbp_pkg::PSS_DRIVE_HI;
            bridge_out_o.d = pair_bd_shutdown_state_reg == fbp_pkg::PSS_DRIVE_HI;
            if (pair_ac_shutdown_state_reg[1]) begin
                bridge_oe_n_o.a = 1'b1;
                bridge_oe_n_o.c = 1'b1;
            end
            if (pair_bd_shutdown_state_reg[1]) begin
                bridge_oe_n_o.b = 1'b1;
                bridge_oe_n_o.d = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence s_steady_fwd;
        full_bridge && !dir_applied_reg && run_reg && dir_state_reg == fbp_pkg::DIR_STEADY;
    endsequence

    sequence s_steady_rev;
        full_bridge && dir_applied_reg && run_reg && dir_state_reg == fbp_pkg::DIR_STEADY;
    endsequence

    sequence s_clear_write;
        wr_shut && !wb_dat_i[fbp_pkg::SC_STATUS_BIT];
    endsequence

    a_forward_steer: assert property (@(posedge clk_i) disable iff (rst_i)
        s_steady_fwd |=> act_reg.a && !act_reg.b && !act_reg.c && act_reg.d == $past(pwm_i))
        else $error("forward steering wrong");

    a_reverse_steer: assert property (@(posedge clk_i) disable iff (rst_i)
        s_steady_rev |=> act_reg.c && !act_reg.a && !act_reg.d && act_reg.b == $past(pwm_i))
        else $error("reverse steering wrong");

    a_dir_in_window: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(dir_applied_reg) && $past(full_bridge) |-> $past(in_window) && !$past(period_end_i))
        else $error("direction applied outside window");

    a_blank_outputs: assert property (@(posedge clk_i) disable iff (rst_i)
        full_bridge && dir_state_reg == fbp_pkg::DIR_BLANK |=> !act_reg.b && !act_reg.d)
        else $error("modulated outputs active during blank");

    a_blank_to_period: assert property (@(posedge clk_i) disable iff (rst_i)
        dir_state_reg == fbp_pkg::DIR_BLANK && full_bridge && !period_end_i
        |=> dir_state_reg == fbp_pkg::DIR_BLANK)
        else $error("blank ended before period start");

    a_status_set: assert property (@(posedge clk_i) disable iff (rst_i)
        src_filt |=> shutdown_event_status_reg [*1] ##1 (src_filt ? shutdown_event_status_reg : 1'b1))
        else $error("status not set by source");

    a_pins_forced: assert property (@(posedge clk_i) disable iff (rst_i)
        shutdown_event_status_reg && full_bridge && pair_ac_shutdown_state_reg == fbp_pkg::PSS_DRIVE_HI
        |-> bridge_out_o.a && bridge_out_o.c && bridge_oe_n_o.a == pin_direction_latch_i.a)
        else $error("pair a/c not forced high");

    a_clear_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        s_clear_write ##0 src_filt |=> shutdown_event_status_reg)
        else $error("clear accepted during shutdown");

    a_restart_period: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(run_reg) |-> $past(period_end_i) && !$past(force_shut))
        else $error("restart off period boundary");

    a_auto_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        auto_restart_enable_reg && shutdown_event_status_reg && !src_filt && !wr_shut && !wr_db
        |=> !shutdown_event_status_reg)
        else $error("auto-restart did not clear status");

endmodule : fbp_bridge

// ---- fbp_drv_model.sv ----
// fbp_drv_model: bridge switch drivers seen as pin levels
`timescale 1ns/1ps
module fbp_drv_model (
    // pin side of the block
    input  wire logic                  clk_i,
    input  wire fbp_pkg::fbp_quad_type out_i,
    input  wire fbp_pkg::fbp_quad_type oe_n_i,
    // resolved pin levels
    output fbp_pkg::fbp_quad_type      pin_o
);
    logic [3:0] last_reg;
    // no pull resistor: a released pin shows the inverse of the level last driven
    always_ff @(posedge clk_i) begin
        last_reg <= (out_i & ~oe_n_i) | (last_reg & oe_n_i);
    end
    assign pin_o = fbp_pkg::fbp_quad_type'((out_i & ~oe_n_i) | (~last_reg & oe_n_i));
endmodule : fbp_drv_model

// ---- fbp_bridge_bench.sv ----
// fbp_bridge_bench: register and pin tests of the full-bridge output stage
`timescale 1ns/1ps
module fbp_bridge_bench;
    logic                  clk_i, rst_i, cyc, stb, we, pwm, pe, ext_int, ack, pd;
    logic [7:0]            adr, tmr, q;
    logic [31:0]           dat, dat_o;
    logic [6:0]            db;
    logic [1:0]            cmp;
    fbp_pkg::fbp_quad_type outs, oe_n, pins;
    int                    bad_count, checked;
    localparam logic [7:0] LIM = 8'h0f;
    fbp_bridge dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .pwm_i(pwm), .period_end_i(pe), .period_timer_count_i(tmr),
        .period_limit_register_i(LIM), .ext_int_pin_i(ext_int),
        .comparator_output_i(cmp), .pin_direction_latch_i(4'h0),
        .bridge_out_o(outs), .bridge_oe_n_o(oe_n), .deadband_delay_o(db));
    fbp_drv_model drv_u (.clk_i(clk_i), .out_i(outs), .oe_n_i(oe_n), .pin_o(pins));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // free running time base, timer rolls over at the limit
    always @(posedge clk_i) begin
        if (rst_i) begin
            {tmr, pe, pwm, pd} <= '0;
        end else begin
            tmr <= (tmr == LIM) ? 8'h00 : tmr + 8'h01;
            pe  <= (tmr == LIM);
            pwm <= (tmr < 8'h06);
            pd  <= pwm;
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= {24'h00_0000, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic at_tmr(input logic [7:0] v);
        do @(negedge clk_i); while (tmr !== v);
    endtask : at_tmr
    // expected bridge outputs follow the pwm of the previous cycle
    task automatic run_chk(input logic rev);
        at_tmr(8'h01);
        repeat (16) begin
            @(negedge clk_i);
            chk({4'h0, outs}, rev ? {5'h00, pd, 2'h2} : {5'h01, 2'h0, pd});
        end
    endtask : run_chk
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out
    initial begin
        #100000;
        bad_count++;
        close_out();
    end
    initial begin
        {cyc, stb, we, adr, dat, cmp, bad_count, checked} = '0;
        ext_int = 1'b1;
        rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, fbp_pkg::REG_UNIT_CTRL, 8'h00);
        chk(q, 8'h00);
        wb(1'b0, 8'h40, 8'h00);
        chk(q, 8'h00);
        wb(1'b1, fbp_pkg::REG_UNIT_CTRL, 8'h40);
        run_chk(1'b0);
        $display("test forward done");
        at_tmr(8'h02);
        wb(1'b1, fbp_pkg::REG_UNIT_CTRL, 8'hc0);
        at_tmr(8'h08);
        chk({4'h0, outs}, {5'h01, 2'h0, pd});
        at_tmr(LIM - 8'h01);
        chk({4'h0, outs}, 8'h02);
        run_chk(1'b1);
        $display("test direction done");
        wb(1'b1, fbp_pkg::REG_SHUT_CTRL, 8'h46);
        @(posedge clk_i);
        ext_int <= 1'b0;
        #1 chk({4'h0, oe_n.b, oe_n.d, pins.a, pins.c}, 8'h0f);
        repeat (8) @(posedge clk_i);
        wb(1'b0, fbp_pkg::REG_SHUT_CTRL, 8'h00);
        chk(q, 8'hc6);
        wb(1'b1, fbp_pkg::REG_SHUT_CTRL, 8'h46);
        wb(1'b0, fbp_pkg::REG_SHUT_CTRL, 8'h00);
        chk(q, 8'hc6);
        ext_int <= 1'b1;
        repeat (8) @(posedge clk_i);
        wb(1'b0, fbp_pkg::REG_SHUT_CTRL, 8'h00);
        chk(q, 8'hc6);
        wb(1'b1, fbp_pkg::REG_SHUT_CTRL, 8'h46);
        wb(1'b0, fbp_pkg::REG_SHUT_CTRL, 8'h00);
        chk(q, 8'h46);
        run_chk(1'b1);
        $display("test shutdown done");
        wb(1'b1, fbp_pkg::REG_SHUT_CTRL, 8'hc6);
        wb(1'b0, fbp_pkg::REG_SHUT_CTRL, 8'h00);
        chk(q, 8'hc6);
        chk({4'h0, pins.a, pins.c, oe_n.b, oe_n.d}, 8'h0f);
        wb(1'b1, fbp_pkg::REG_DB_RESTART, 8'h85);
        repeat (3) @(posedge clk_i);
        chk({1'b0, db}, 8'h05);
        wb(1'b0, fbp_pkg::REG_SHUT_CTRL, 8'h00);
        chk(q, 8'h46);
        run_chk(1'b1);
        wb(1'b1, fbp_pkg::REG_UNIT_CTRL, 8'hc3);
        at_tmr(8'h03);
        chk({4'h0, outs}, {4'h0, 1'b1, ~pd, 2'h1});
        wb(1'b0, fbp_pkg::REG_STATE, 8'h00);
        chk(q, 8'h05);
        $display("test restart and polarity done");
        wb(1'b1, fbp_pkg::REG_SHUT_CTRL, 8'h15);
        @(posedge clk_i);
        cmp <= 2'h1;
        #1 chk({4'h0, outs}, 8'h0f);
        repeat (8) @(posedge clk_i);
        wb(1'b0, fbp_pkg::REG_SHUT_CTRL, 8'h00);
        chk(q, 8'h95);
        cmp <= 2'h0;
        repeat (8) @(posedge clk_i);
        wb(1'b0, fbp_pkg::REG_SHUT_CTRL, 8'h00);
        chk(q, 8'h15);
        $display("test comparator shutdown done");
        close_out();
    end
endmodule : fbp_bridge_bench
